// File: shared/uart_port_pkg.sv
// constants shared by the uart host port and serial channel
package uart_port_pkg;
  // register addresses on the 4-bit host address
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STAT_CSEL = 4'h1;
  localparam logic [3:0] ADDR_CMD = 4'h2;
  localparam logic [3:0] ADDR_DATA = 4'h3;
  localparam logic [3:0] ADDR_CHG_AUX = 4'h4;
  localparam logic [3:0] ADDR_INT = 4'h5;
  localparam logic [3:0] ADDR_CTR_HI = 4'h6;
  localparam logic [3:0] ADDR_CTR_LO = 4'h7;
  localparam logic [3:0] ADDR_BAUD = 4'h8;
  localparam logic [3:0] ADDR_VECTOR = 4'h9;
  localparam logic [3:0] ADDR_OUT_CFG = 4'ha;
  localparam logic [3:0] ADDR_IN_SET = 4'hb;
  localparam logic [3:0] ADDR_OUT_CLR = 4'hc;
  // command codes in command bits 6:4
  localparam logic [2:0] CMD_PTR_RST = 3'h1;
  localparam logic [2:0] CMD_ERR_RST = 3'h2;
  localparam logic [2:0] CMD_CTR_GO = 3'h3;
  localparam logic [2:0] CMD_CTR_STOP = 3'h4;
  // mode register field positions
  localparam int MODE1_RX_RTS = 7;
  localparam int MODE2_LOOP = 7;
  localparam int MODE2_TX_RTS = 5;
  localparam int MODE2_CTS_EN = 4;
  // output configuration field positions
  localparam int CFG_OUT4_RXINT = 2;
  localparam int CFG_OUT6_TXINT = 3;
  localparam logic [1:0] OUT2_GEN = 2'h0;
  localparam logic [1:0] OUT2_TX16 = 2'h1;
  localparam logic [1:0] OUT2_TX1 = 2'h2;
  localparam logic [1:0] OUT2_RX1 = 2'h3;
  // reset values
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] VECTOR_RST = 8'h0f;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // timing
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] HALF_BIT_START = 4'h8;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_W = 9;
endpackage

// File: src/uart_port.sv
// uart host bus port, serial channel, multipurpose pins and tx fifo
`timescale 1ns/1ps
// Summary of operation
// - Chip select low enables data transfers; high floats the data lines unless interrupt acknowledge is low.
// - Read/write high means read, low means write, while chip select is low.
// - Interrupt acknowledge puts the vector on the bus and asserts transfer ack.
// - Transfer ack asserts on every read, write and acknowledge cycle.
// - Four address bits pick one internal register per access.
// - Reset clears status, masks, outputs config; outputs high, counter stopped, pointer first.
// - Interrupt request pulls low while any of five masked conditions holds.
// - Receiver: high is mark, low is space, least significant bit first.
// - Transmitter sends lsb first, holds mark when disabled, idle or looped back.
// - Output zero is general output or request-to-send with auto negation.
// - Output two: general output, tx 1x/16x clock or rx 1x clock.
// - Output four: general output or open-drain receive interrupt.
// - Output six: general output or open-drain transmit interrupt.
// - Input zero is general input or clear-to-send for flow control.
// - Inputs zero to three record changes of state.
// - Input two may clock the counter/timer.
// - External tx clock shifts each bit out on its falling edge.
// - External rx clock samples data on its rising edge.
module uart_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 16)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  // pointers one bit wider so full and empty differ
  assign in_ready_o = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o = mem[rd_q[AW-1:0]];
  always_ff @(posedge mclk_i)
  begin
    if (in_valid_i && in_ready_o)
      mem[wr_q[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (in_valid_i && in_ready_o)
        wr_q <= wr_q + 1'b1;
      if (out_valid_o && out_ready_i)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule

module uart_port
  import uart_port_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic chip_select_n_i,
  input wire logic read_not_write_i,
  input wire logic int_ack_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic transfer_ack_n_o,
  output logic transfer_ack_n_oe_o,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  input wire logic serial_in_i,
  output logic serial_out_o,
  input wire logic [5:0] gen_in_i,
  output logic [7:0] gen_out_o,
  output logic [7:0] gen_out_oe_o
);
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} ser_state_t;
  logic [SYNC_W-1:0] raw, s1_q, s2_q, s3_q, filt_q, prev_q;
  logic cs_n, iack_n, rx_pin, in0_cts_n, in2_rise, in3_fall, in4_rise;
  bus_state_t bus_q;
  logic [7:0] mode1_q, mode2_q, csel_q, aux_q, int_mask_q, vector_q, out_cfg_q, out_port_q, baud_q;
  logic [7:0] ctr_hi_q, ctr_lo_q, rx_hold_q, int_stat;
  logic mode_ptr_q, rx_en_q, tx_en_q, rx_rdy_q, overrun_q, frame_q, ctr_rdy_q, ctr_run_q;
  logic [3:0] chg_q;
  logic [15:0] ctr_q;
  logic [7:0] div_q;
  logic tick_q, tx16_q;
  logic do_acc, wr_acc, rd_acc, fifo_in_rdy, fifo_vld, fifo_pop;
  logic [7:0] fifo_dat;
  ser_state_t tx_q, rx_q;
  logic [3:0] tx_ph_q, rx_ph_q;
  logic [2:0] tx_cnt_q, rx_cnt_q;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic tx_line_q, tx_bit, rx_samp, rx_bit, rx_done;

  // acknowledge, chip select, serial and general inputs pass three flops; a change counts when flops two and three agree
  assign raw = {int_ack_n_i, chip_select_n_i, serial_in_i, gen_in_i};
  for (genvar g = 0; g < SYNC_W; g++)
  begin : g_sync
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        s1_q[g] <= 1'b1;
        s2_q[g] <= 1'b1;
        s3_q[g] <= 1'b1;
        filt_q[g] <= 1'b1;
        prev_q[g] <= 1'b1;
      end
      else
      begin
        s1_q[g] <= raw[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g])
          filt_q[g] <= s3_q[g];
        prev_q[g] <= filt_q[g];
      end
    end
  end
  assign iack_n = filt_q[8];
  assign cs_n = filt_q[7];
  assign rx_pin = filt_q[6]; // high is mark
  assign in0_cts_n = filt_q[0];
  assign in2_rise = filt_q[2] && !prev_q[2];
  assign in3_fall = !filt_q[3] && prev_q[3];
  assign in4_rise = filt_q[4] && !prev_q[4];

  // bus cycle: a tx data write waits for fifo room, stretching the acknowledge
  assign do_acc = (bus_q == BUS_IDLE) && (!cs_n || !iack_n)
    && !(!cs_n && iack_n && !read_not_write_i && addr_i == ADDR_DATA && !fifo_in_rdy);
  assign wr_acc = do_acc && iack_n && !read_not_write_i;
  assign rd_acc = do_acc && iack_n && read_not_write_i;
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      bus_q <= BUS_IDLE;
    else if (do_acc)
      bus_q <= BUS_ACK;
    else if (bus_q == BUS_ACK && cs_n && iack_n)
      bus_q <= BUS_IDLE;
  end
  assign transfer_ack_n_o = bus_q != BUS_ACK;
  assign transfer_ack_n_oe_o = !cs_n || !iack_n || bus_q == BUS_ACK;
  assign data_oe_o = bus_q == BUS_ACK && !cs_n_or_write(cs_n, iack_n, read_not_write_i);

  function automatic logic cs_n_or_write(input logic c_n, input logic a_n, input logic rnw);
    cs_n_or_write = a_n && (c_n || !rnw);
  endfunction

  // read data captured when the access is taken
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      data_o <= 8'h00;
    else if (do_acc && !iack_n)
      data_o <= vector_q;
    else if (rd_acc)
    begin
      case (addr_i)
        ADDR_MODE: data_o <= mode_ptr_q ? mode2_q : mode1_q;
        ADDR_STAT_CSEL: data_o <= {2'b00, frame_q, overrun_q, !fifo_vld && tx_q == SER_IDLE, fifo_in_rdy, 1'b0, rx_rdy_q};
        ADDR_DATA: data_o <= rx_hold_q;
        ADDR_CHG_AUX: data_o <= {chg_q, filt_q[3:0]};
        ADDR_INT: data_o <= int_stat;
        ADDR_CTR_HI: data_o <= ctr_q[15:8];
        ADDR_CTR_LO: data_o <= ctr_q[7:0];
        ADDR_BAUD: data_o <= baud_q;
        ADDR_VECTOR: data_o <= vector_q;
        ADDR_OUT_CFG: data_o <= out_cfg_q;
        ADDR_IN_SET: data_o <= {2'b00, filt_q[5:0]};
        default: data_o <= 8'h00;
      endcase
    end
  end

  // host-written configuration; reset clears masks, port and config
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode1_q <= ZERO_RST;
      mode2_q <= ZERO_RST;
      mode_ptr_q <= 1'b0;
      csel_q <= ZERO_RST;
      aux_q <= ZERO_RST;
      int_mask_q <= ZERO_RST;
      vector_q <= VECTOR_RST;
      out_cfg_q <= ZERO_RST;
      baud_q <= BAUD_RST;
      ctr_hi_q <= ZERO_RST;
      ctr_lo_q <= ZERO_RST;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end
    else
    begin
      if ((wr_acc || rd_acc) && addr_i == ADDR_MODE)
        mode_ptr_q <= 1'b1;
      if (wr_acc)
      begin
        case (addr_i)
          ADDR_MODE: if (mode_ptr_q) mode2_q <= data_i; else mode1_q <= data_i;
          ADDR_STAT_CSEL: csel_q <= data_i;
          ADDR_CMD:
          begin
            if (data_i[0]) rx_en_q <= 1'b1;
            if (data_i[1]) rx_en_q <= 1'b0;
            if (data_i[2]) tx_en_q <= 1'b1;
            if (data_i[3]) tx_en_q <= 1'b0;
            if (data_i[6:4] == CMD_PTR_RST) mode_ptr_q <= 1'b0;
          end
          ADDR_CHG_AUX: aux_q <= data_i;
          ADDR_INT: int_mask_q <= data_i;
          ADDR_CTR_HI: ctr_hi_q <= data_i;
          ADDR_CTR_LO: ctr_lo_q <= data_i;
          ADDR_BAUD: baud_q <= data_i;
          ADDR_VECTOR: vector_q <= data_i;
          ADDR_OUT_CFG: out_cfg_q <= data_i;
          default: ;
        endcase
      end
    end
  end

  // output port bits; rts negates on its own when rx holds a char or tx is disabled and drained
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      out_port_q <= ZERO_RST; // pins read high
    else if (wr_acc && addr_i == ADDR_IN_SET)
      out_port_q <= out_port_q | data_i;
    else if (wr_acc && addr_i == ADDR_OUT_CLR)
      out_port_q <= out_port_q & ~data_i;
    else if ((mode1_q[MODE1_RX_RTS] && rx_rdy_q)
      || (mode2_q[MODE2_TX_RTS] && !tx_en_q && !fifo_vld && tx_q == SER_IDLE))
      out_port_q[0] <= 1'b0;
  end

  // status flags: hardware set wins over the clearing read or command
  assign rx_done = rx_q == SER_STOP && rx_samp;
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_rdy_q <= 1'b0;
      overrun_q <= 1'b0;
      frame_q <= 1'b0;
      rx_hold_q <= 8'h00;
      chg_q <= 4'h0;
    end
    else
    begin
      if (rd_acc && addr_i == ADDR_DATA)
        rx_rdy_q <= 1'b0;
      if (wr_acc && addr_i == ADDR_CMD && data_i[6:4] == CMD_ERR_RST)
      begin
        overrun_q <= 1'b0;
        frame_q <= 1'b0;
      end
      if (rx_done && rx_en_q)
      begin
        rx_rdy_q <= 1'b1;
        rx_hold_q <= rx_sh_q;
        frame_q <= !rx_bit;
        if (rx_rdy_q && !(rd_acc && addr_i == ADDR_DATA))
          overrun_q <= 1'b1;
      end
      chg_q <= ((rd_acc && addr_i == ADDR_CHG_AUX) ? 4'h0 : chg_q) | (filt_q[3:0] ^ prev_q[3:0]);
    end
  end
  assign int_stat = {3'b000, overrun_q, ctr_rdy_q, |chg_q, rx_rdy_q, fifo_in_rdy && tx_en_q};
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = |(int_stat & int_mask_q);

  // counter/timer from the clock or input two; stopped by reset
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctr_run_q <= 1'b0;
      ctr_rdy_q <= 1'b0;
      ctr_q <= 16'h0000;
    end
    else if (wr_acc && addr_i == ADDR_CMD && data_i[6:4] == CMD_CTR_GO)
    begin
      ctr_run_q <= 1'b1;
      ctr_q <= {ctr_hi_q, ctr_lo_q};
    end
    else if (wr_acc && addr_i == ADDR_CMD && data_i[6:4] == CMD_CTR_STOP)
    begin
      ctr_run_q <= 1'b0;
      ctr_rdy_q <= 1'b0;
    end
    else if (ctr_run_q && (!aux_q[0] || in2_rise))
    begin
      ctr_q <= (ctr_q == 16'h0000) ? {ctr_hi_q, ctr_lo_q} : ctr_q - 16'h0001;
      if (ctr_q == 16'h0000)
        ctr_rdy_q <= 1'b1;
    end
  end

  // 16x tick from the baud divisor
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
      tx16_q <= 1'b0;
    end
    else
    begin
      tick_q <= div_q == baud_q;
      div_q <= (div_q == baud_q) ? 8'h00 : div_q + 8'h01;
      if (tick_q)
        tx16_q <= !tx16_q;
    end
  end

  // transmitter; external clock shifts on its falling edge
  assign tx_bit = csel_q[0] ? in3_fall : (tick_q && tx_ph_q == OVERSAMPLE_LAST);
  assign fifo_pop = tx_q == SER_IDLE && tx_en_q && fifo_vld && tx_bit
    && !(mode2_q[MODE2_CTS_EN] && in0_cts_n);
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_q <= SER_IDLE;
      tx_ph_q <= 4'h0;
      tx_cnt_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_line_q <= 1'b1; // mark
    end
    else
    begin
      if (tick_q)
        tx_ph_q <= tx_ph_q + 4'h1;
      case (tx_q)
        SER_IDLE:
        begin
          tx_line_q <= 1'b1;
          if (fifo_pop)
          begin
            tx_sh_q <= fifo_dat;
            tx_line_q <= 1'b0;
            tx_q <= SER_START;
          end
        end
        SER_START, SER_DATA:
          if (tx_bit)
          begin
            // start slot sends bit 0, seven data slots follow, so the stop bit never eats bit 7
            if (tx_q == SER_DATA && tx_cnt_q == 3'h7)
            begin
              tx_line_q <= 1'b1;
              tx_cnt_q <= 3'h0;
              tx_q <= SER_STOP;
            end
            else
            begin
              tx_line_q <= tx_sh_q[0]; // lsb first
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              if (tx_q == SER_START)
                tx_q <= SER_DATA;
              else
                tx_cnt_q <= tx_cnt_q + 3'h1;
            end
          end
        SER_STOP:
          if (tx_bit)
            tx_q <= SER_IDLE;
        default: tx_q <= SER_IDLE;
      endcase
    end
  end
  assign serial_out_o = tx_line_q || mode2_q[MODE2_LOOP]; // mark in loopback

  // receiver; external clock samples on its rising edge
  assign rx_bit = mode2_q[MODE2_LOOP] ? tx_line_q : rx_pin;
  assign rx_samp = csel_q[4] ? in4_rise : (tick_q && rx_ph_q == OVERSAMPLE_LAST);
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_q <= SER_IDLE;
      rx_ph_q <= 4'h0;
      rx_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end
    else
    begin
      if (tick_q)
        rx_ph_q <= rx_ph_q + 4'h1;
      case (rx_q)
        SER_IDLE:
          if (!rx_bit && !csel_q[4])
          begin
            rx_ph_q <= HALF_BIT_START; // centre of the start bit
            rx_q <= SER_START;
          end
          else if (!rx_bit && rx_samp)
            rx_q <= SER_DATA;
        SER_START:
          if (rx_samp)
            rx_q <= rx_bit ? SER_IDLE : SER_DATA; // glitch rejected
        SER_DATA:
          if (rx_samp)
          begin
            rx_sh_q <= {rx_bit, rx_sh_q[7:1]}; // lsb first
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == 3'h7)
              rx_q <= SER_STOP;
          end
        SER_STOP:
          if (rx_samp)
            rx_q <= SER_IDLE;
        default: rx_q <= SER_IDLE;
      endcase
    end
  end

  uart_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .in_valid_i(wr_acc && addr_i == ADDR_DATA), .in_ready_o(fifo_in_rdy), .in_data_i(data_i),
    .out_valid_o(fifo_vld), .out_ready_i(fifo_pop), .out_data_o(fifo_dat));

  // multipurpose output pins; pin level is the inverse of the port bit
  always_comb
  begin
    gen_out_o = ~out_port_q;
    gen_out_oe_o = 8'hff;
    case (out_cfg_q[1:0])
      OUT2_TX16: gen_out_o[2] = tx16_q;
      OUT2_TX1: gen_out_o[2] = tx_ph_q[3];
      OUT2_RX1: gen_out_o[2] = rx_ph_q[3];
      default: gen_out_o[2] = ~out_port_q[2];
    endcase
    if (out_cfg_q[CFG_OUT4_RXINT])
    begin
      gen_out_o[4] = 1'b0;
      gen_out_oe_o[4] = int_stat[1];
    end
    if (out_cfg_q[CFG_OUT6_TXINT])
    begin
      gen_out_o[6] = 1'b0;
      gen_out_oe_o[6] = int_stat[0];
    end
  end

  sequence s_ack_cycle;
    bus_q == BUS_ACK && !iack_n;
  endsequence
  a_bus_float: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (cs_n && iack_n) |-> !data_oe_o) else $error("data bus driven while idle");
  a_vector_ack: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_ack_cycle |-> data_o == vector_q && data_oe_o && !transfer_ack_n_o) else $error("vector not presented");
  a_ack_taken: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    do_acc |=> !transfer_ack_n_o) else $error("ack missing");
  a_ack_release: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (bus_q == BUS_ACK && cs_n && iack_n) |=> transfer_ack_n_o && !data_oe_o) else $error("bus not released");
  a_irq_mask: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (int_mask_q == 8'h00) |-> !irq_n_oe_o) else $error("irq with all masked");
  a_tx_mark: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (tx_q == SER_IDLE && !fifo_pop) |=> serial_out_o) else $error("tx not mark");
  a_tx_lsb: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (tx_q == SER_START && tx_bit && !mode2_q[MODE2_LOOP]) |=> serial_out_o == $past(tx_sh_q[0]))
    else $error("tx bit order");
  a_cts_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (tx_q == SER_IDLE && mode2_q[MODE2_CTS_EN] && in0_cts_n) |=> tx_q == SER_IDLE) else $error("sent without cts");
  a_chg_seen: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (filt_q[3:0] != prev_q[3:0]) |=> chg_q != 4'h0) else $error("change lost");
  a_rx_int_pin: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (out_cfg_q[CFG_OUT4_RXINT] && rx_rdy_q) |-> gen_out_oe_o[4] && !gen_out_o[4]) else $error("rx pin idle");
endmodule

// File: dv/host_model.sv
// host processor model for the acknowledge-style bus
`timescale 1ns/1ps
module host_model
(
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rdata_oe_i,
  input wire logic ack_n_i,
  input wire logic ack_oe_i,
  output logic cs_n_o,
  output logic rnw_o,
  output logic iack_n_o,
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o
);
  // bus configuration tie-low has no pin here: this model only speaks the acknowledge style
  initial
  begin
    cs_n_o = 1'b1;
    iack_n_o = 1'b1;
    rnw_o = 1'b1;
    addr_o = 4'h0;
    wdata_o = 8'h00;
  end

  // one access; signals change at falling edges and stand until ack is seen
  task automatic access(input logic iack, input logic rnw, input logic [3:0] a, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    rd = 8'h00;
    @(negedge mclk_i);
    addr_o = a;
    rnw_o = rnw;
    wdata_o = rnw ? ~wdata_o : wd;
    if (iack)
    begin
      iack_n_o = 1'b0;
    end
    else
    begin
      cs_n_o = 1'b0;
    end
    while (n < 200 && !ok)
    begin
      @(negedge mclk_i);
      n++;
      if (ack_oe_i === 1'b1 && ack_n_i === 1'b0)
      begin
        ok = 1'b1;
        rd = (rdata_oe_i === 1'b1) ? rdata_i : 8'hxx;
      end
    end
    // released bus lines flip so a stale value never looks valid
    cs_n_o = 1'b1;
    iack_n_o = 1'b1;
    wdata_o = ~wdata_o;
    addr_o = ~addr_o;
    n = 0;
    while (n < 200 && (ack_oe_i !== 1'b0 || rdata_oe_i !== 1'b0))
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 200)
    begin
      ok = 1'b0;
    end
  endtask
endmodule

// File: dv/tb_uart_async_bus_pin_functions.sv
// testbench for the uart host port and pins
`timescale 1ns/1ps
module tb_uart_async_bus_pin_functions;
  import uart_port_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n, rnw, iack_n, data_oe, ack_n, ack_oe, irq_n, irq_oe, ser_out;
  logic ser_in = 1'b1;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, gen_out, gen_oe, rd;
  logic [5:0] gen_in = 6'h3f;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #4 mclk = ~mclk;

  uart_port uut (.mclk_i(mclk), .arst_n_i(arst_n), .chip_select_n_i(cs_n), .read_not_write_i(rnw),
    .int_ack_n_i(iack_n), .addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe),
    .transfer_ack_n_o(ack_n), .transfer_ack_n_oe_o(ack_oe), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe),
    .serial_in_i(ser_in), .serial_out_o(ser_out), .gen_in_i(gen_in), .gen_out_o(gen_out),
    .gen_out_oe_o(gen_oe));

  host_model host (.mclk_i(mclk), .rdata_i(rdata), .rdata_oe_i(data_oe), .ack_n_i(ack_n),
    .ack_oe_i(ack_oe), .cs_n_o(cs_n), .rnw_o(rnw), .iack_n_o(iack_n), .addr_o(addr), .wdata_o(wdata));

  task automatic stop_test();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bus cycles; a missing or stuck ack counts as a mismatch
  task automatic bus(input logic iack, input logic rnw_v, input logic [3:0] a, input logic [7:0] d);
    logic ok;
    host.access(iack, rnw_v, a, d, rd, ok);
    check("ack", 8'h01, {7'h0, ok});
  endtask

  // hang guard well above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      stop_test();
    end
  end

  task automatic t_reset();
    check("ser_out", 8'h01, {7'h0, ser_out});
    check("gen_out", 8'hff, gen_out);
    check("gen_oe", 8'hff, gen_oe);
    check("data_oe", 8'h00, {7'h0, data_oe});
    check("ack_oe", 8'h00, {7'h0, ack_oe});
    check("irq_oe", 8'h00, {7'h0, irq_oe});
  endtask

  task automatic t_vector();
    bus(1'b1, 1'b1, 4'h0, 8'h00);
    check("vector", VECTOR_RST, rd);
    bus(1'b0, 1'b0, ADDR_VECTOR, 8'h5a);
    bus(1'b0, 1'b1, ADDR_VECTOR, 8'h00);
    check("vector rd", 8'h5a, rd);
    bus(1'b1, 1'b1, 4'h0, 8'h00);
    check("vector ack", 8'h5a, rd);
    bus(1'b0, 1'b1, 4'hd, 8'h00);
    check("unmapped", 8'h00, rd);
  endtask

  task automatic t_outport();
    bus(1'b0, 1'b0, ADDR_IN_SET, 8'h41);
    check("out set", 8'hbe, gen_out);
    bus(1'b0, 1'b0, ADDR_OUT_CLR, 8'h41);
    check("out clr", 8'hff, gen_out);
  endtask

  // change-of-state latch on input one, cleared by the read
  task automatic t_change();
    @(negedge mclk);
    gen_in[1] = 1'b0;
    repeat (10) @(negedge mclk);
    bus(1'b0, 1'b1, ADDR_CHG_AUX, 8'h00);
    check("change", 8'h2d, rd);
    bus(1'b0, 1'b1, ADDR_CHG_AUX, 8'h00);
    check("change clr", 8'h0d, rd);
  endtask

  // divisor 0 gives one tick per clock, so a bit lasts 16 clocks
  task automatic t_tx();
    logic [7:0] got;
    int n;
    bus(1'b0, 1'b0, ADDR_CMD, 8'h04);
    check("tx idle", 8'h01, {7'h0, ser_out});
    fork
      bus(1'b0, 1'b0, ADDR_DATA, 8'ha5);
      begin
        n = 0;
        while (n < 400 && ser_out !== 1'b0)
        begin
          @(negedge mclk);
          n++;
        end
        repeat (8) @(negedge mclk);
        check("start", 8'h00, {7'h0, ser_out});
        for (int i = 0; i < 8; i++)
        begin
          repeat (16) @(negedge mclk);
          got[i] = ser_out;
        end
        repeat (16) @(negedge mclk);
        check("stop", 8'h01, {7'h0, ser_out});
      end
    join
    check("tx byte", 8'ha5, got);
  endtask

  // rx byte with rts auto negation, rx interrupt on output four and the 16x clock on output two
  task automatic t_rx();
    logic [9:0] frame;
    logic b;
    frame = {1'b1, 8'h3c, 1'b0};
    bus(1'b0, 1'b0, ADDR_CMD, 8'h01);
    bus(1'b0, 1'b0, ADDR_INT, 8'h02);
    bus(1'b0, 1'b0, ADDR_MODE, 8'h80);
    bus(1'b0, 1'b0, ADDR_IN_SET, 8'h01);
    bus(1'b0, 1'b0, ADDR_OUT_CFG, 8'h05);
    check("irq idle", 8'h00, {7'h0, irq_oe});
    check("rts on", 8'h00, {7'h0, gen_out[0]});
    check("out4 idle", 8'h00, {7'h0, gen_oe[4]});
    b = gen_out[2];
    @(negedge mclk);
    check("out2 clock", {7'h0, ~b}, {7'h0, gen_out[2]});
    for (int i = 0; i < 10; i++)
    begin
      @(negedge mclk);
      ser_in = frame[i];
      repeat (15) @(negedge mclk);
    end
    repeat (32) @(negedge mclk);
    check("irq rx", 8'h01, {7'h0, irq_oe});
    check("irq level", 8'h00, {7'h0, irq_n});
    check("rts auto", 8'h01, {7'h0, gen_out[0]});
    check("out4 rx", 8'h01, {7'h0, gen_oe[4]});
    check("out4 low", 8'h00, {7'h0, gen_out[4]});
    bus(1'b0, 1'b1, ADDR_DATA, 8'h00);
    check("rx byte", 8'h3c, rd);
    check("irq clr", 8'h00, {7'h0, irq_oe});
    check("out4 clr", 8'h00, {7'h0, gen_oe[4]});
  endtask

  // clear-to-send gate: a queued byte waits while input zero is high
  task automatic t_cts();
    int n;
    bus(1'b0, 1'b0, ADDR_MODE, 8'h10);
    bus(1'b0, 1'b0, ADDR_DATA, 8'h96);
    n = 0;
    repeat (40)
    begin
      @(negedge mclk);
      if (ser_out !== 1'b1)
        n++;
    end
    check("cts held", 8'h00, n[7:0]);
    gen_in[0] = 1'b0;
    n = 0;
    while (n < 40 && ser_out !== 1'b0)
    begin
      @(negedge mclk);
      n++;
    end
    check("cts go", 8'h00, {7'h0, ser_out});
    repeat (200) @(negedge mclk);
  endtask

  initial
  begin
    repeat (16) @(negedge mclk);
    arst_n = 1'b1;
    t_reset();
    repeat (4) @(negedge mclk);
    t_vector();
    t_outport();
    t_change();
    t_tx();
    t_rx();
    t_cts();
    stop_test();
  end
endmodule
